// ==== tb/sctc_bus_model.sv ====
// other bus master: issues cycles that the snooper watches
`timescale 1ns/1ns
module sctc_bus_model (
   input wire logic mclk,
   output logic bus_clock_qualifier,
   output sctc_pkg::sctc_bus_t bus_in
);
   initial begin
      bus_clock_qualifier = 1'b1;
      bus_in = '0;
   end
   // held for one bus period of r clocks, qualified on its first edge if q
   task automatic cycle(input logic [31:0] a, input logic s, o, q,
      input int r);
      for (int i = 0; i < r; i++) begin
         @(posedge mclk);
         bus_clock_qualifier <= q && (i == 0);
         bus_in <= '{1'b1, o, s, a};
      end
      @(posedge mclk);
      bus_clock_qualifier <= 1'b1;
      bus_in <= '{1'b0, 1'b0, 1'b0, ~a};
   endtask : cycle
endmodule : sctc_bus_model

// ==== tb/sctc_monitor.sv ====
// port checker for the cache tag control, bound to its top module
`timescale 1ns/1ns
module sctc_monitor (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic bus_clock_qualifier,
   input wire sctc_pkg::sctc_bus_t bus_in,
   input wire sctc_pkg::sctc_req_t req,
   input wire logic req_stall,
   input wire sctc_pkg::sctc_rsp_t rsp,
   input wire logic snoop_inval
);
   logic [3:0] quiet;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence taken;
      req.valid && !req_stall;
   endsequence
   // cycles since the last qualified foreign snoopable bus cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) quiet <= 4'hF;
      else if (bus_clock_qualifier && bus_in.start && bus_in.other_master
         && bus_in.snoopable) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
   end
   a_done_after_take: assert property (taken |=> rsp.done)
      else $error("no response after accepted request");
   a_done_needs_take: assert property (!req.valid |=> !rsp.done)
      else $error("response without request");
   a_stall_holds_off: assert property (req_stall |=> !rsp.done)
      else $error("stalled request answered");
   a_stall_needs_req: assert property (req_stall |-> req.valid)
      else $error("stall without request");
   a_stall_cause: assert property (req_stall |-> quiet <= 4'h8)
      else $error("stall without pending snoop");
   a_inval_cause: assert property (snoop_inval |-> quiet <= 4'h8)
      else $error("invalidate without qualified snoop");
   a_hit_is_valid: assert property (rsp.done && rsp.hit
      |-> rsp.line_state != sctc_pkg::SCTC_INVALID)
      else $error("hit on invalid line");
   a_state_legal: assert property (rsp.done |-> rsp.line_state inside
      {sctc_pkg::SCTC_INVALID, sctc_pkg::SCTC_VALID, sctc_pkg::SCTC_DIRTY})
      else $error("illegal line state");
   a_icache_clean: assert property (taken ##1 $past(req.icache)
      |-> rsp.line_state != sctc_pkg::SCTC_DIRTY)
      else $error("dirty instruction line");
   a_evict_on_miss: assert property (rsp.evict_dirty
      |-> rsp.done && !rsp.hit)
      else $error("eviction reported on hit");
endmodule : sctc_monitor
bind sctc_top sctc_monitor mon (.mclk, .rst_b, .bus_clock_qualifier,
   .bus_in, .req, .req_stall, .rsp, .snoop_inval);

// ==== tb/sctc_tb_top.sv ====
// self-checking bench for the cache tag control
`timescale 1ns/1ns
module sctc_tb_top;
   logic mclk;
   logic rst_b;
   logic bus_clock_qualifier;
   sctc_pkg::sctc_bus_t bus_in;
   sctc_pkg::sctc_req_t req;
   logic req_stall;
   sctc_pkg::sctc_rsp_t rsp;
   logic snoop_inval;
   int n_errors;
   int total_checks;
   sctc_top dut (.mclk, .rst_b, .bus_clock_qualifier, .bus_in, .req,
      .req_stall, .rsp, .snoop_inval);
   sctc_bus_model bm (.mclk, .bus_clock_qualifier, .bus_in);
   always #20 mclk = ~mclk;
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic ex(input sctc_pkg::sctc_op_t op, input logic ic, cb,
      input logic [31:0] a);
      int n;
      n = 0;
      @(posedge mclk);
      req <= '{1'b1, op, ic, cb, a};
      #1;
      while (req_stall !== 1'b0) begin
         n++;
         if (n > 20) begin
            n_errors++;
            finish_test;
         end
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      req.valid <= 1'b0;
      #1;
      chk(rsp.done, 1);
   endtask : ex
   task automatic s_ways;
      int h;
      h = 0;
      for (int t = 1; t < 6; t++) ex(sctc_pkg::SCTC_OP_FILL, 0, 0,
         {21'(t), 7'h05, 4'h0});
      for (int t = 1; t < 6; t++) begin
         ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'(t), 7'h05, 4'h0});
         h += int'(rsp.hit);
      end
      chk(8'(h), 4);
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'h5, 7'h05, 4'hF});
      chk(rsp.hit, 1);
      chk(rsp.line_state, sctc_pkg::SCTC_VALID);
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'h5, 7'h06, 4'h0});
      chk(rsp.hit, 0);
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'h5, 7'h05, 4'h0} + 32'h2000);
      chk(rsp.hit, 0);
      ex(sctc_pkg::SCTC_OP_READ, 1, 0, {21'h5, 7'h05, 4'h0});
      chk(rsp.hit, 0);
   endtask : s_ways
   task automatic s_writes;
      ex(sctc_pkg::SCTC_OP_FILL, 0, 0, {21'h7, 7'h20, 4'h0});
      ex(sctc_pkg::SCTC_OP_WRITE, 0, 1, {21'h7, 7'h20, 4'h4});
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'h7, 7'h20, 4'h0});
      chk(rsp.line_state, sctc_pkg::SCTC_DIRTY);
      chk(rsp.way, 1);
      ex(sctc_pkg::SCTC_OP_WRITE, 0, 0, {21'h8, 7'h20, 4'h0});
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'h8, 7'h20, 4'h0});
      chk(rsp.hit, 0);
      ex(sctc_pkg::SCTC_OP_WRITE, 0, 1, {21'h9, 7'h20, 4'h0});
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'h9, 7'h20, 4'h0});
      chk(rsp.hit, 1);
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'hA, 7'h20, 4'h0});
      chk(rsp.evict_dirty, 0);
      chk(rsp.way, 0);
      ex(sctc_pkg::SCTC_OP_FILL, 0, 0, {21'hA, 7'h20, 4'h0});
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, {21'hB, 7'h20, 4'h0});
      chk(rsp.way, 1);
      chk(rsp.evict_dirty, 1);
      chk(rsp.evict_tag, 32'h7);
   endtask : s_writes
   // bus cycle while the execution unit keeps requesting
   task automatic s_snoop(input logic [31:0] a, input logic s, o, q,
      input int r, input logic e);
      int st;
      int iv;
      st = 0;
      iv = 0;
      ex(sctc_pkg::SCTC_OP_FILL, 0, 0, a);
      ex(sctc_pkg::SCTC_OP_FILL, 1, 0, a);
      fork
         bm.cycle(a, s, o, q, r);
         for (int i = 0; i < 14; i++) begin
            @(posedge mclk);
            req <= '{1'b1, sctc_pkg::SCTC_OP_READ, 1'b0, 1'b0, 32'h0};
            #1;
            st += int'(req_stall);
            iv += int'(snoop_inval);
         end
      join
      chk(iv, e);
      chk(st, e);
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, a);
      chk(rsp.hit, !e);
      ex(sctc_pkg::SCTC_OP_READ, 1, 0, a);
      chk(rsp.hit, !e);
   endtask : s_snoop
   task automatic s_icache;
      logic [31:0] a;
      a = {21'hD, 7'h40, 4'h0};
      ex(sctc_pkg::SCTC_OP_FILL, 1, 0, a);
      ex(sctc_pkg::SCTC_OP_FILL, 0, 0, a);
      ex(sctc_pkg::SCTC_OP_READ, 1, 0, a + 32'h8);
      chk(rsp.hit, 1);
      chk(rsp.line_state, sctc_pkg::SCTC_VALID);
      ex(sctc_pkg::SCTC_OP_WRITE, 1, 1, a);
      ex(sctc_pkg::SCTC_OP_READ, 1, 0, a);
      chk(rsp.line_state, sctc_pkg::SCTC_VALID);
      ex(sctc_pkg::SCTC_OP_INVAL, 1, 0, a);
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, a);
      chk(rsp.hit, 1);
      ex(sctc_pkg::SCTC_OP_READ, 1, 0, a);
      chk(rsp.hit, 0);
      ex(sctc_pkg::SCTC_OP_INVAL, 0, 0, a);
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, a);
      chk(rsp.hit, 0);
   endtask : s_icache
   // reset lands on the edge that takes a fill
   task automatic s_reset;
      @(posedge mclk);
      req <= '{1'b1, sctc_pkg::SCTC_OP_FILL, 1'b0, 1'b0, 32'h0000_5000};
      @(posedge mclk);
      req.valid <= 1'b0;
      rst_b <= 1'b0;
      #1;
      chk(rsp.done, 0);
      chk(snoop_inval, 0);
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      ex(sctc_pkg::SCTC_OP_READ, 0, 0, 32'h0000_5000);
      chk(rsp.hit, 0);
      chk(rsp.way, sctc_pkg::RST_VICTIM);
   endtask : s_reset
   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      req = '0;
      n_errors = 0;
      total_checks = 0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      s_ways;
      s_writes;
      s_snoop({21'h1, 7'h30, 4'h0}, 0, 1, 1, 1, 0);
      s_snoop({21'h2, 7'h30, 4'h0}, 1, 0, 1, 1, 0);
      s_snoop({21'h3, 7'h30, 4'h0}, 1, 1, 1, 2, 1);
      s_snoop({21'h4, 7'h30, 4'h0}, 1, 1, 1, 4, 1);
      s_snoop({21'h5, 7'h30, 4'h0}, 1, 1, 0, 2, 0);
      s_icache;
      s_reset;
      finish_test;
   end
endmodule : sctc_tb_top

// ==== verilog/sctc_pkg.sv ====
// shared constants and carrier types for the snooping cache tag control
package sctc_pkg;
   localparam int ADDR_W = 32;
   localparam int WAYS = 4;
   localparam int LINE_BYTES = 16;
   localparam int CACHE_BYTES = 8192;
   localparam int SETS = CACHE_BYTES / (LINE_BYTES * WAYS);
   localparam int OFS_LSB = 0;
   localparam int IDX_LSB = 4;
   localparam int IDX_MSB = 10;
   localparam int TAG_LSB = 11;
   localparam int TAG_W = ADDR_W - TAG_LSB;
   localparam int IDX_W = IDX_MSB - IDX_LSB + 1;
   localparam logic [1:0] RST_VICTIM = 2'h0;

   typedef enum logic [1:0] {
      SCTC_INVALID,
      SCTC_VALID,
      SCTC_DIRTY
   } sctc_line_t;

   typedef enum logic [2:0] {
      SCTC_OP_READ,
      SCTC_OP_WRITE,
      SCTC_OP_FILL,
      SCTC_OP_INVAL
   } sctc_op_t;

   // request from the execution unit
   typedef struct packed {
      logic valid;
      sctc_op_t op;
      logic icache;
      logic copyback;
      logic [ADDR_W-1:0] addr;
   } sctc_req_t;

   // cycle observed on the external bus
   typedef struct packed {
      logic start;
      logic other_master;
      logic snoopable;
      logic [ADDR_W-1:0] addr;
   } sctc_bus_t;

   // lookup answer to the execution unit
   typedef struct packed {
      logic done;
      logic hit;
      logic [1:0] way;
      sctc_line_t line_state;
      logic evict_dirty;
      logic [TAG_W-1:0] evict_tag;
   } sctc_rsp_t;
endpackage : sctc_pkg

// ==== verilog/sctc_tag_way.sv ====
// one way of a tag array: tag and state per set, with compare
`timescale 1ns/1ns
module sctc_tag_way #(
   parameter int SETS = sctc_pkg::SETS,
   parameter int IDX_W = sctc_pkg::IDX_W,
   parameter int TAG_W = sctc_pkg::TAG_W,
   parameter bit THREE_STATE = 1'b1
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [IDX_W-1:0] idx,
   input wire logic [TAG_W-1:0] tag,
   input wire logic wr,
   input wire logic [TAG_W-1:0] wr_tag,
   input wire sctc_pkg::sctc_line_t wr_state,
   output logic hit,
   output sctc_pkg::sctc_line_t state,
   output logic [TAG_W-1:0] stored_tag
);
   logic [TAG_W-1:0] tag_mem [SETS];
   sctc_pkg::sctc_line_t st_mem [SETS];
   sctc_pkg::sctc_line_t w_state;

   // the instruction cache never holds a dirty line
   always_comb begin
      w_state = wr_state;
      if (!THREE_STATE && wr_state == sctc_pkg::SCTC_DIRTY) begin
         w_state = sctc_pkg::SCTC_VALID;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < SETS; i++) begin
            st_mem[i] <= sctc_pkg::SCTC_INVALID;
         end
      end else if (wr) begin
         st_mem[idx] <= w_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (wr) begin
         tag_mem[idx] <= wr_tag;
      end
   end

   assign state = st_mem[idx];
   assign stored_tag = tag_mem[idx];
   assign hit = (st_mem[idx] != sctc_pkg::SCTC_INVALID)
      && (tag_mem[idx] == tag);
endmodule : sctc_tag_way

// ==== verilog/sctc_top.sv ====
// tag, state and snoop control for the instruction and data caches
`timescale 1ns/1ns
// Operation
// - both caches are four-way set associative with 16-byte lines
// - each line keeps an address tag and a state showing validity
// - data lines are invalid, valid clean, or dirty
// - snoopable foreign cycles invalidate hits; others skip lookup
// - snooper wins the arrays over the execution unit in the same cycle
// - bus signals are sampled on rising edges of the input clock
// - bus activity counts only on edges qualified by the clock qualifier
// - each cache holds eight kilobytes, physically indexed and tagged
// - copyback or write-through per page; write-through misses skip fill
module sctc_top (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic bus_clock_qualifier,
   input wire sctc_pkg::sctc_bus_t bus_in,
   input wire sctc_pkg::sctc_req_t req,
   output logic req_stall,
   output sctc_pkg::sctc_rsp_t rsp,
   output logic snoop_inval
);
   localparam int W = sctc_pkg::WAYS;

   typedef struct packed {
      logic qual_s1;
      logic qual_s2;
      sctc_pkg::sctc_bus_t bus_s1;
      sctc_pkg::sctc_bus_t bus_s2;
      logic snoop_pend;
      logic [sctc_pkg::ADDR_W-1:0] snoop_addr;
      logic [1:0] victim;
      sctc_pkg::sctc_rsp_t rsp;
      logic snoop_inval;
   } sctc_state_t;

   sctc_state_t cur;
   sctc_state_t next_cur;

   logic snoop_go;
   logic cpu_go;
   logic [sctc_pkg::ADDR_W-1:0] look_addr;
   logic [sctc_pkg::IDX_W-1:0] idx;
   logic [sctc_pkg::TAG_W-1:0] tag;
   logic [W-1:0] i_hit;
   logic [W-1:0] d_hit;
   logic [W-1:0] i_wr;
   logic [W-1:0] d_wr;
   sctc_pkg::sctc_line_t i_st [W];
   sctc_pkg::sctc_line_t d_st [W];
   logic [sctc_pkg::TAG_W-1:0] d_tag [W];
   sctc_pkg::sctc_line_t wr_state;
   logic [1:0] hit_way;
   logic any_hit;
   logic use_icache;
   logic victim_dirty;

   // snooper owns the arrays when a snoop is pending
   // a pending snoop steers its own address onto the index and tag path
   assign snoop_go = cur.snoop_pend;
   assign cpu_go = req.valid && !snoop_go;
   assign req_stall = req.valid && snoop_go;
   assign look_addr = snoop_go ? cur.snoop_addr : req.addr;
   assign idx = look_addr[sctc_pkg::IDX_MSB:sctc_pkg::IDX_LSB];
   assign tag = look_addr[sctc_pkg::ADDR_W-1:sctc_pkg::TAG_LSB];
   assign use_icache = req.icache;

   // each way index carries one instruction way and one data way
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_way
         sctc_tag_way #(
            .THREE_STATE(1'b0)
         ) u_iway (
            .mclk(mclk),
            .rst_b(rst_b),
            .idx(idx),
            .tag(tag),
            .wr(i_wr[g]),
            .wr_tag(tag),
            .wr_state(wr_state),
            .hit(i_hit[g]),
            .state(i_st[g]),
            .stored_tag()
         );
         sctc_tag_way #(
            .THREE_STATE(1'b1)
         ) u_dway (
            .mclk(mclk),
            .rst_b(rst_b),
            .idx(idx),
            .tag(tag),
            .wr(d_wr[g]),
            .wr_tag(tag),
            .wr_state(wr_state),
            .hit(d_hit[g]),
            .state(d_st[g]),
            .stored_tag(d_tag[g])
         );
      end
   endgenerate

   // lowest hitting way is reported; a tag lives in one way at most
   always_comb begin
      hit_way = 2'h0;
      for (int k = W - 1; k >= 0; k--) begin
         if (use_icache ? i_hit[k] : d_hit[k]) begin
            hit_way = 2'(k);
         end
      end
   end
   assign any_hit = use_icache ? |i_hit : |d_hit;
   // a data miss onto a dirty victim hands its tag out for copyback
   assign victim_dirty = !use_icache
      && d_st[cur.victim] == sctc_pkg::SCTC_DIRTY;

   // array write decisions
   always_comb begin
      i_wr = '0;
      d_wr = '0;
      wr_state = sctc_pkg::SCTC_INVALID;
      if (snoop_go) begin
         // every hitting way of both caches is cleared at once
         i_wr = i_hit;
         d_wr = d_hit;
         wr_state = sctc_pkg::SCTC_INVALID;
      end else if (cpu_go) begin
         case (req.op)
            sctc_pkg::SCTC_OP_READ: begin
               wr_state = sctc_pkg::SCTC_INVALID;
            end
            sctc_pkg::SCTC_OP_WRITE: begin
               // copyback hit goes dirty; write-through leaves the line state unchanged
               if (!use_icache && any_hit && req.copyback) begin
                  d_wr[hit_way] = 1'b1;
                  wr_state = sctc_pkg::SCTC_DIRTY;
               end else if (!use_icache && !any_hit && req.copyback) begin
                  d_wr[cur.victim] = 1'b1;
                  wr_state = sctc_pkg::SCTC_DIRTY;
               end
               // write-through miss allocates nothing
               // the instruction cache ignores writes
            end
            sctc_pkg::SCTC_OP_FILL: begin
               // a fill that hits refreshes its way instead of a victim
               wr_state = sctc_pkg::SCTC_VALID;
               if (use_icache) begin
                  i_wr[any_hit ? hit_way : cur.victim] = 1'b1;
               end else begin
                  d_wr[any_hit ? hit_way : cur.victim] = 1'b1;
               end
            end
            sctc_pkg::SCTC_OP_INVAL: begin
               wr_state = sctc_pkg::SCTC_INVALID;
               if (use_icache) begin
                  i_wr = i_hit;
               end else begin
                  d_wr = d_hit;
               end
            end
            default: begin
               wr_state = sctc_pkg::SCTC_INVALID;
            end
         endcase
      end
   end

   always_comb begin
      next_cur = cur;
      // two flops on the bus inputs before any logic reads them
      next_cur.qual_s1 = bus_clock_qualifier;
      next_cur.qual_s2 = cur.qual_s1;
      next_cur.bus_s1 = bus_in;
      next_cur.bus_s2 = cur.bus_s1;
      next_cur.snoop_inval = 1'b0;
      next_cur.rsp = '0;
      if (snoop_go) begin
         next_cur.snoop_pend = 1'b0;
         next_cur.snoop_inval = |i_hit || |d_hit;
      end
      // a snoop arriving as the pending one clears keeps the flag set
      // only qualified edges latch a bus cycle
      if (cur.qual_s2 && cur.bus_s2.start && cur.bus_s2.other_master
          && cur.bus_s2.snoopable) begin
         next_cur.snoop_pend = 1'b1;
         next_cur.snoop_addr = cur.bus_s2.addr;
      end
      if (cpu_go) begin
         next_cur.rsp.done = 1'b1;
         next_cur.rsp.hit = any_hit;
         next_cur.rsp.way = any_hit ? hit_way : cur.victim;
         next_cur.rsp.line_state = use_icache ? i_st[hit_way]
            : d_st[hit_way];
         if (!any_hit) begin
            next_cur.rsp.line_state = sctc_pkg::SCTC_INVALID;
            if (victim_dirty) begin
               next_cur.rsp.evict_dirty = 1'b1;
               next_cur.rsp.evict_tag = d_tag[cur.victim];
            end
         end
         // round-robin victim moves only when a line is written
         if (|i_wr || |d_wr) begin
            next_cur.victim = cur.victim + 2'h1;
         end
      end
   end

   // reset empties the answer and restarts the victim count
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cur <= '0;
         cur.victim <= sctc_pkg::RST_VICTIM;
      end else begin
         cur <= next_cur;
      end
   end

   assign rsp = cur.rsp;
   assign snoop_inval = cur.snoop_inval;
endmodule : sctc_top
